/* common/usb_port_pkg.sv */
// constants and types shared by the port control slice and its helpers
package usb_port_pkg;

	// ------------------------------------------------------------------
	// register map (byte addresses on the apb bus)
	// ------------------------------------------------------------------
	localparam int          ADDR_W         = 12;
	localparam logic [11:0] PORT_OFS       = 12'h000;
	localparam logic [11:0] ROUTE_OFS      = 12'h004;
	localparam logic [11:0] PARAMS_OFS     = 12'h008;
	localparam logic [11:0] IRQ_STAT_OFS   = 12'h00C;
	localparam logic [11:0] IRQ_MASK_OFS   = 12'h010;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int          TEST_LSB       = 16;
	localparam int          TEST_W         = 4;
	localparam int          OWNED_BIT      = 13;
	localparam int          POWER_BIT      = 12;
	localparam int          LINE_PLUS_BIT  = 11;
	localparam int          LINE_MINUS_BIT = 10;
	localparam int          CFG_BIT        = 0;
	localparam int          PSW_BIT        = 4;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [3:0]  TEST_RST       = 4'h0;
	localparam logic        OWNED_RST      = 1'b1;
	localparam logic        POWER_RST      = 1'b0;
	localparam logic        CFG_RST        = 1'b0;
	localparam logic [1:0]  LINE_RST       = 2'h0;
	localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

	// ------------------------------------------------------------------
	// test mode encodings, modes are consecutive from TEST_J upward
	// ------------------------------------------------------------------
	localparam logic [3:0]  TEST_OFF       = 4'h0;
	localparam logic [3:0]  TEST_J         = 4'h1;
	localparam int          TEST_MODES     = 5;

	// ------------------------------------------------------------------
	// interrupt events
	// ------------------------------------------------------------------
	localparam int          EV_W           = 3;
	localparam int          EV_OVERCUR     = 0;
	localparam int          EV_LINE        = 1;
	localparam int          EV_OWNER       = 2;
	localparam logic [2:0]  EV_RST         = 3'h0;

	// bus handshake states, one bit apart along the only path
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RESP = 1'b1
	} apb_state_e;

endpackage

/* common/port_ctl_if.sv */
// carrier between the port control core and its two helpers
`timescale 1ns/1ps
`default_nettype none
interface port_ctl_if;
	import usb_port_pkg::*;
	logic [TEST_W-1:0]     test_select;
	logic [TEST_MODES-1:0] test_onehot;
	logic                  powered;
	logic [1:0]            line_state;
	logic                  line_change;

	modport core    (output test_select, output powered,
	                 input test_onehot, input line_state, input line_change);
	modport decoder (input test_select, output test_onehot);
	modport monitor (input powered, output line_state, output line_change);
endinterface
`default_nettype wire

/* rtl/test_mode_decode.sv */
// decodes the test selection into one line per test mode
`timescale 1ns/1ps
`default_nettype none
module test_mode_decode
	import usb_port_pkg::*;
(
	port_ctl_if.decoder ctl
);
	// one compare per mode; reserved codes light nothing
	for (genvar i = 0; i < TEST_MODES; i++) begin : g_mode
		assign ctl.test_onehot[i] =
			(ctl.test_select == TEST_J + TEST_W'(i));
	end
endmodule
`default_nettype wire

/* rtl/line_state_monitor.sv */
// samples the data line levels while powered and flags each change
`timescale 1ns/1ps
`default_nettype none
module line_state_monitor
	import usb_port_pkg::*;
(
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire logic   plus_line,
	input  wire logic   minus_line,
	port_ctl_if.monitor ctl
);
	logic [1:0] line_ff;
	logic       change_ff;

	// unpowered port shows zero and never reports a change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_ff   <= LINE_RST;
			change_ff <= 1'b0;
		end else if (ctl.powered) begin
			line_ff   <= {plus_line, minus_line};
			change_ff <= (line_ff != {plus_line, minus_line});
		end else begin
			line_ff   <= LINE_RST;
			change_ff <= 1'b0;
		end
	end

	assign ctl.line_state  = line_ff;
	assign ctl.line_change = change_ff;
endmodule
`default_nettype wire

/* rtl/usb_port_control.sv */
// port test, ownership, power and line state slice with apb registers
`timescale 1ns/1ps
`default_nettype none
module usb_port_control
	import usb_port_pkg::*;
#(
	parameter bit PSW_PRESENT = 1'b1
)(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              plus_line,
	input  wire logic              minus_line,
	input  wire logic              overcurrent,
	output logic                   port_power_en,
	output logic                   companion_route,
	output logic                   hs_route,
	output logic                   test_drive_j,
	output logic                   test_drive_k,
	output logic                   test_se0_nak,
	output logic                   test_packet_send,
	output logic                   test_force_enable,
	output logic                   irq
);

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	if (TEST_MODES != 5) begin : g_bad_modes
		$error("test mode decoder expects exactly five modes");
	end

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	apb_state_e            state_ff;
	apb_state_e            nxt_state;
	logic [31:0]           prdata_ff;
	logic                  pready_ff;
	logic                  pslverr_ff;
	logic [TEST_W-1:0]     test_select_ff;
	logic                  companion_owned_ff;
	logic                  supply_switch_on_ff;
	logic                  configure_flag_ff;
	logic                  cfg_prev_ff;
	logic [EV_W-1:0]       irq_stat_ff;
	logic [EV_W-1:0]       irq_mask_ff;
	logic                  irq_ff;
	logic [TEST_MODES-1:0] test_out_ff;
	logic                  route_ff;
	logic                  hs_ff;
	logic [31:0]           rd_word;
	logic                  addr_hit;
	logic                  wr_commit;
	logic                  rd_commit;
	logic                  wr_port;
	logic                  wr_route;
	logic                  wr_stat;
	logic                  wr_mask;
	logic                  cfg_rise;
	logic                  power_read;
	logic                  oc_cut;
	logic                  owner_next;
	logic                  owner_evt;
	logic [EV_W-1:0]       ev_set;

	port_ctl_if ctl ();

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// decoder turns the stored code into per-mode strobes
	test_mode_decode u_decode (
		.ctl (ctl.decoder)
	);

	// monitor samples the data lines only while powered
	line_state_monitor u_lines (
		.pclk       (pclk),
		.presetn    (presetn),
		.plus_line  (plus_line),
		.minus_line (minus_line),
		.ctl        (ctl.monitor)
	);

	assign ctl.test_select = test_select_ff;
	assign ctl.powered     = power_read;

	// ------------------------------------------------------------------
	// apb handshake
	// ------------------------------------------------------------------
	// one wait state so that prdata and pready come from flops
	always_comb begin
		case (state_ff)
			ST_IDLE: nxt_state = (psel && penable) ? ST_RESP : ST_IDLE;
			ST_RESP: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// address decode; anything outside the map answers with pslverr
	always_comb begin
		case (paddr)
			PORT_OFS,
			ROUTE_OFS,
			PARAMS_OFS,
			IRQ_STAT_OFS,
			IRQ_MASK_OFS: addr_hit = 1'b1;
			default:      addr_hit = 1'b0;
		endcase
	end

	// writes land only at the edge where pready is seen high
	assign wr_commit = psel && penable && pready_ff && pwrite && addr_hit;
	assign rd_commit = (nxt_state == ST_RESP);
	assign wr_port   = wr_commit && (paddr == PORT_OFS);
	assign wr_route  = wr_commit && (paddr == ROUTE_OFS);
	assign wr_stat   = wr_commit && (paddr == IRQ_STAT_OFS);
	assign wr_mask   = wr_commit && (paddr == IRQ_MASK_OFS);

	// read mux; reserved bits read as zero
	always_comb begin
		rd_word = ZERO_WORD;
		case (paddr)
			PORT_OFS: begin
				rd_word[TEST_LSB +: TEST_W] = test_select_ff;
				rd_word[OWNED_BIT]          = companion_owned_ff;
				rd_word[POWER_BIT]          = power_read;
				rd_word[LINE_PLUS_BIT]      = ctl.line_state[1];
				rd_word[LINE_MINUS_BIT]     = ctl.line_state[0];
			end
			ROUTE_OFS:    rd_word[CFG_BIT] = configure_flag_ff;
			PARAMS_OFS:   rd_word[PSW_BIT] = PSW_PRESENT;
			IRQ_STAT_OFS: rd_word[EV_W-1:0] = irq_stat_ff;
			IRQ_MASK_OFS: rd_word[EV_W-1:0] = irq_mask_ff;
			default:      rd_word = ZERO_WORD;
		endcase
	end

	// response flops: data and error are held with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= ZERO_WORD;
		end else begin
			pready_ff  <= rd_commit;
			pslverr_ff <= rd_commit && !addr_hit;
			if (rd_commit && !pwrite) begin
				prdata_ff <= rd_word;
			end
		end
	end

	// ------------------------------------------------------------------
	// test mode selection
	// ------------------------------------------------------------------
	// stored as written; reserved codes are kept but select no mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_select_ff <= TEST_RST;
		end else if (wr_port) begin
			test_select_ff <= pwdata[TEST_LSB +: TEST_W];
		end
	end

	// registered strobes; code zero leaves every strobe low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_out_ff <= '0;
		end else if (test_select_ff == TEST_OFF) begin
			test_out_ff <= '0;
		end else begin
			test_out_ff <= ctl.test_onehot;
		end
	end

	// ------------------------------------------------------------------
	// routing configure flag
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			configure_flag_ff <= CFG_RST;
			cfg_prev_ff       <= CFG_RST;
		end else begin
			if (wr_route) begin
				configure_flag_ff <= pwdata[CFG_BIT];
			end
			cfg_prev_ff <= configure_flag_ff;
		end
	end

	assign cfg_rise = configure_flag_ff && !cfg_prev_ff;

	// ------------------------------------------------------------------
	// port ownership
	// ------------------------------------------------------------------
	// forcing wins over the rising edge, which wins over software
	always_comb begin
		if (!configure_flag_ff) begin
			owner_next = 1'b1;
		end else if (cfg_rise) begin
			owner_next = 1'b0;
		end else if (wr_port) begin
			owner_next = pwdata[OWNED_BIT];
		end else begin
			owner_next = companion_owned_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			companion_owned_ff <= OWNED_RST;
		end else begin
			companion_owned_ff <= owner_next;
		end
	end

	assign owner_evt = (owner_next != companion_owned_ff);

	// routing follows ownership, so the flag sets the default
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_ff <= OWNED_RST;
			hs_ff    <= CFG_RST;
		end else begin
			route_ff <= companion_owned_ff;
			hs_ff    <= !companion_owned_ff && configure_flag_ff;
		end
	end

	// ------------------------------------------------------------------
	// port power switch
	// ------------------------------------------------------------------
	// overcurrent on a switched-on port takes precedence over a software write in the same cycle
	assign oc_cut = PSW_PRESENT && supply_switch_on_ff && overcurrent;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_switch_on_ff <= POWER_RST;
		end else if (oc_cut) begin
			supply_switch_on_ff <= 1'b0;
		end else if (wr_port && PSW_PRESENT) begin
			supply_switch_on_ff <= pwdata[POWER_BIT];
		end
	end

	// without switches the port reads as permanently powered; port_power_en stays low
	assign power_read = PSW_PRESENT ? supply_switch_on_ff : 1'b1;

	// ------------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------------
	// unpowered port raises no line or ownership event
	always_comb begin
		ev_set              = '0;
		ev_set[EV_OVERCUR]  = oc_cut;
		ev_set[EV_LINE]     = ctl.line_change && power_read;
		ev_set[EV_OWNER]    = owner_evt && power_read;
	end

	// write one clears; a new event in the same cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= EV_RST;
		end else begin
			irq_stat_ff <= ev_set |
				(irq_stat_ff & ~(wr_stat ? pwdata[EV_W-1:0] : EV_RST));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_ff <= EV_RST;
		end else if (wr_mask) begin
			irq_mask_ff <= pwdata[EV_W-1:0];
		end
	end

	// level interrupt, high while any enabled bit stands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	// ------------------------------------------------------------------
	// outputs, all straight from flops
	// ------------------------------------------------------------------
	assign prdata            = prdata_ff;
	assign pready            = pready_ff;
	assign pslverr           = pslverr_ff;
	assign port_power_en     = supply_switch_on_ff;
	assign companion_route   = route_ff;
	assign hs_route          = hs_ff;
	assign test_drive_j      = test_out_ff[0];
	assign test_drive_k      = test_out_ff[1];
	assign test_se0_nak      = test_out_ff[2];
	assign test_packet_send  = test_out_ff[3];
	assign test_force_enable = test_out_ff[4];
	assign irq               = irq_ff;

endmodule
`default_nettype wire

/* verif/usb_port_control_props.sv */
// assertion checker watching the port control slice pins
`timescale 1ns/1ps
`default_nettype none
module usb_port_control_props
	import usb_port_pkg::*;
#(
	parameter bit PSW_PRESENT = 1'b1
)(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              plus_line,
	input wire logic              minus_line,
	input wire logic              overcurrent,
	input wire logic              port_power_en,
	input wire logic              companion_route,
	input wire logic              hs_route,
	input wire logic              test_drive_j,
	input wire logic              test_drive_k,
	input wire logic              test_se0_nak,
	input wire logic              test_packet_send,
	input wire logic              test_force_enable,
	input wire logic              irq
);
	// ------------------------------
	// helper state
	// ------------------------------
	logic       cfg_ff;
	logic [2:0] mask_ff;
	logic [1:0] line_ff;
	logic [1:0] age_ff;
	logic       wr_ok;
	logic       wr_port;
	logic       mapped;
	logic [4:0] want_strobe;
	logic [4:0] strobe_vec;

	// committed writes only; a refused write changes nothing
	assign wr_ok = psel && penable && pready && pwrite && !pslverr;
	assign wr_port = wr_ok && paddr == PORT_OFS;
	assign mapped = paddr inside {PORT_OFS, ROUTE_OFS, PARAMS_OFS,
		IRQ_STAT_OFS, IRQ_MASK_OFS};
	assign want_strobe = (pwdata[19:16] inside {[4'h1:4'h5]}) ?
		5'h01 << (pwdata[19:16] - 4'h1) : 5'h00;
	assign strobe_vec = {test_force_enable, test_packet_send,
		test_se0_nak, test_drive_k, test_drive_j};

	// shadow of the flag and mask, taken from the bus itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff  <= CFG_RST;
			mask_ff <= EV_RST;
		end else if (wr_ok && paddr == ROUTE_OFS) begin
			cfg_ff <= pwdata[CFG_BIT];
		end else if (wr_ok && paddr == IRQ_MASK_OFS) begin
			mask_ff <= pwdata[2:0];
		end
	end

	// age of a steady line level on a powered port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_ff <= LINE_RST;
			age_ff  <= 2'd0;
		end else begin
			line_ff <= {plus_line, minus_line};
			if (!port_power_en || {plus_line, minus_line} != line_ff)
				age_ff <= 2'd0;
			else if (age_ff != 2'd3)
				age_ff <= age_ff + 2'd1;
		end
	end

	// ------------------------------
	// properties
	// ------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_cfg_rise;
		wr_ok && paddr == ROUTE_OFS && pwdata[CFG_BIT] && !cfg_ff;
	endsequence

	a_apb_one_wait: assert property (s_setup ##1 s_access |=>
		pready ##1 !pready) else $error("pready timing wrong");
	a_slverr_map: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr does not match address map");
	a_test_strobes: assert property (
		wr_port |-> ##2 strobe_vec == $past(want_strobe, 2))
		else $error("test strobes do not match written code");
	a_owner_forced: assert property (
		(!cfg_ff) [*3] |-> companion_route && !hs_route)
		else $error("companion not owning with flag low");
	a_owner_clear: assert property (
		s_cfg_rise |-> ##[2:3] (!companion_route && hs_route))
		else $error("owner not cleared on flag rise");
	a_power_follow: assert property (
		PSW_PRESENT && wr_port && !overcurrent |=>
		port_power_en == $past(pwdata[POWER_BIT]))
		else $error("power pin not following write");
	a_overcur_cut: assert property (
		PSW_PRESENT && port_power_en && overcurrent |=> !port_power_en)
		else $error("overcurrent did not cut power");
	a_irq_masked: assert property ((mask_ff == 3'h0) [*2] |-> !irq)
		else $error("irq high with all events masked");
	a_line_mirror: assert property (
		pready && !pwrite && paddr == PORT_OFS && age_ff == 2'd3 |->
		prdata[11:10] == line_ff)
		else $error("line state read differs from pins");
endmodule
`default_nettype wire

/* verif/usb_device_model.sv */
// behavioural downstream device driving the two data lines
`timescale 1ns/1ps
`default_nettype none
module usb_device_model (
	input  wire logic       attached,
	input  wire logic       powered,
	input  wire logic       self_powered,
	input  wire logic [1:0] idle_code,
	output logic            plus_line,
	output logic            minus_line
);
	// an absent or dark device leaves both lines to the host pull-downs
	always_comb begin
		if (attached && (powered || self_powered)) begin
			plus_line  = idle_code[1];
			minus_line = idle_code[0];
		end else begin
			plus_line  = 1'b0;
			minus_line = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* verif/tb_usb_port_owner_power_test.sv */
// self-checking bench for the port control slice
`timescale 1ns/1ps
`default_nettype none
module tb_usb_port_owner_power_test;
	import usb_port_pkg::*;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic [31:0]       prdata_nosw;
	logic              pready;
	logic              pslverr;
	logic              plus_line;
	logic              minus_line;
	logic              overcurrent;
	logic              power_on;
	logic              power_nosw;
	logic              comp;
	logic              hs;
	logic [4:0]        strobes;
	logic              irq;
	logic              attached;
	logic              self_pwr;
	logic [1:0]        idle_code;
	logic [31:0]       rd;
	logic              err;
	int                mismatches = 0;
	int                samples_checked = 0;
	int                cycles = 0;
	int                seed = 32'hb14b;

	usb_port_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.plus_line(plus_line), .minus_line(minus_line),
		.overcurrent(overcurrent), .port_power_en(power_on),
		.companion_route(comp), .hs_route(hs), .test_drive_j(strobes[0]),
		.test_drive_k(strobes[1]), .test_se0_nak(strobes[2]),
		.test_packet_send(strobes[3]), .test_force_enable(strobes[4]),
		.irq(irq));
	// switchless twin on the same bus, only its read data and power pin are watched
	usb_port_control #(.PSW_PRESENT(1'b0)) dut_nosw (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata_nosw), .pready(),
		.pslverr(), .plus_line(plus_line), .minus_line(minus_line),
		.overcurrent(overcurrent), .port_power_en(power_nosw),
		.companion_route(), .hs_route(), .test_drive_j(), .test_drive_k(),
		.test_se0_nak(), .test_packet_send(), .test_force_enable(), .irq());
	usb_device_model dev_u (.attached(attached), .powered(power_on),
		.self_powered(self_pwr), .idle_code(idle_code),
		.plus_line(plus_line), .minus_line(minus_line));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ------------------------------
	// shared tasks
	// ------------------------------
	function automatic logic [4:0] want_strobes(input logic [3:0] c);
		want_strobes = 5'h00;
		if (c >= TEST_J && c <= 4'h5)
			want_strobes = 5'h01 << (c - TEST_J);
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// pready, data and error are taken at the rising edge they stand at
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		logic got;
		int   n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			got = pready;
			rd = prdata;
			err = pslverr;
			n++;
		end while (got !== 1'b1 && n < 16);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) check("pready", 32'h1, 32'h0);
	endtask

	task automatic rdc(input string what, input logic [ADDR_W-1:0] a,
		input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, ZERO_WORD);
		check(what, exp & m, rd & m);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict();
		end
	end

	// ------------------------------
	// scenarios
	// ------------------------------
	initial begin
		logic [1:0] code;
		logic [3:0] tc;
		{psel, penable, pwrite, overcurrent, attached, self_pwr} = 6'h00;
		paddr = '0;
		pwdata = ZERO_WORD;
		idle_code = 2'b00;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdc("port", PORT_OFS, 32'hFFFF_FFFF, 32'h2000);
		check("fixed power", 32'h1000, prdata_nosw & 32'h1000);
		rdc("route", ROUTE_OFS, 32'hFFFF_FFFF, ZERO_WORD);
		rdc("params", PARAMS_OFS, 32'h10, 32'h10);
		check("routes", 32'h1, 32'({hs, comp}));
		// unmapped word: refused, write lost, reads zero
		apb(1'b1, 12'h020, 32'hFFFF_FFFF);
		check("slverr", 32'h1, 32'(err));
		rdc("unmapped", 12'h020, 32'hFFFF_FFFF, ZERO_WORD);
		check("slverr", 32'h1, 32'(err));
		// power on; the twin has no switch to turn
		apb(1'b1, PORT_OFS, 32'h0000_1000);
		cyc(1);
		check("power", 32'h1, 32'(power_on));
		check("twin power", 32'h0, 32'(power_nosw));
		// random idle levels, the low-speed level last
		for (int i = 0; i < 9; i++) begin
			code = (i == 8) ? 2'b01 : 2'($random(seed));
			@(posedge pclk);
			attached <= 1'b1;
			idle_code <= code;
			cyc(4);
			rdc("lines", PORT_OFS, 32'h0C00, {20'h0, code, 10'h0});
		end
		// flag rising takes the port from the companion
		apb(1'b1, ROUTE_OFS, 32'h1);
		cyc(3);
		check("owner clear", 32'h2, 32'({hs, comp}));
		rdc("owner bit", PORT_OFS, 32'h2000, ZERO_WORD);
		// software reads the idle level while connected and not enabled;
		// only a K level hands over, other levels stay for a reset here
		if (rd[11:10] == 2'b01) begin
			apb(1'b1, PORT_OFS, 32'h3000);
		end
		cyc(2);
		check("released", 32'h1, 32'({hs, comp}));
		// flag low: writing a zero owner bit does not stick
		apb(1'b1, ROUTE_OFS, ZERO_WORD);
		apb(1'b1, PORT_OFS, 32'h0000_1000);
		rdc("forced", PORT_OFS, 32'h2000, 32'h2000);
		// every test code, reserved ones too, then back to normal
		for (int c = 0; c < 17; c++) begin
			tc = 4'(c);
			apb(1'b1, PORT_OFS, {12'h0, tc, 16'h1000});
			cyc(2);
			check("strobes", 32'(want_strobes(tc)), 32'(strobes));
			rdc("test", PORT_OFS, 32'hF_0000, {12'h0, tc, 16'h0});
		end
		// line and ownership changes on the powered port were reported
		rdc("events", IRQ_STAT_OFS, 32'h6, 32'h6);
		// overcurrent cut, seen first masked, then unmasked and cleared
		apb(1'b1, IRQ_STAT_OFS, 32'h7);
		apb(1'b1, IRQ_MASK_OFS, ZERO_WORD);
		overcurrent <= 1'b1;
		@(posedge pclk);
		overcurrent <= 1'b0;
		cyc(2);
		check("cut", 32'h0, 32'(power_on));
		check("irq masked", 32'h0, 32'(irq));
		rdc("oc event", IRQ_STAT_OFS, 32'h1, 32'h1);
		apb(1'b1, IRQ_MASK_OFS, 32'h1);
		cyc(2);
		check("irq on", 32'h1, 32'(irq));
		apb(1'b1, IRQ_STAT_OFS, 32'h1);
		cyc(2);
		check("irq off", 32'h0, 32'(irq));
		// a self-powered device wiggles lines on the dark port
		apb(1'b1, IRQ_STAT_OFS, 32'h7);
		self_pwr <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			idle_code <= 2'($random(seed)) | 2'b01;
			attached <= ~attached;
		end
		cyc(3);
		rdc("dark lines", PORT_OFS, 32'h0C00, ZERO_WORD);
		rdc("no events", IRQ_STAT_OFS, 32'h7, ZERO_WORD);
		give_verdict();
	end
endmodule

bind usb_port_control usb_port_control_props #(.PSW_PRESENT(PSW_PRESENT))
	chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .plus_line(plus_line),
	.minus_line(minus_line), .overcurrent(overcurrent),
	.port_power_en(port_power_en), .companion_route(companion_route),
	.hs_route(hs_route), .test_drive_j(test_drive_j),
	.test_drive_k(test_drive_k), .test_se0_nak(test_se0_nak),
	.test_packet_send(test_packet_send),
	.test_force_enable(test_force_enable), .irq(irq));
`default_nettype wire
